// ==== hdl/psr_pkg.sv ====
// psr_pkg: offsets, field layout and bus constants of the signature bank
package psr_pkg;
    // byte offsets within the bank
    localparam logic [7:0] OFS_LOT0 = 8'h08;
    localparam logic [7:0] OFS_LOT1 = 8'h09;
    localparam logic [7:0] OFS_LOT2 = 8'h0a;
    localparam logic [7:0] OFS_LOT3 = 8'h0b;
    localparam logic [7:0] OFS_LOT4 = 8'h0c;
    localparam logic [7:0] OFS_LOT5 = 8'h0d;
    localparam logic [7:0] OFS_WAFER = 8'h10;
    localparam logic [7:0] OFS_X_LOW = 8'h12;
    localparam logic [7:0] OFS_X_HIGH = 8'h13;
    localparam logic [7:0] OFS_Y_LOW = 8'h14;
    localparam logic [7:0] OFS_Y_HIGH = 8'h15;
    localparam logic [7:0] OFS_USB_LOW = 8'h1a;
    localparam logic [7:0] OFS_USB_HIGH = 8'h1b;
    localparam logic [7:0] OFS_OSC48 = 8'h1c;
    localparam logic [7:0] OFS_CONVA_LOW = 8'h20;
    localparam logic [7:0] OFS_CONVA_HIGH = 8'h21;
    localparam logic [7:0] OFS_CONVB_LOW = 8'h24;
    localparam logic [7:0] OFS_CONVB_HIGH = 8'h25;
    localparam logic [7:0] OFS_TEMP_LOW = 8'h2e;
    localparam logic [7:0] OFS_TEMP_HIGH = 8'h2f;
    // bank holds 64 byte slots, one per 32-bit word index
    localparam int BANK_DEPTH = 64;
    localparam int BANK_AW = 6;
    // wafer number keeps its upper three bits at zero
    localparam logic [7:0] WAFER_MASK = 8'h1f;
    // temperature result is 12 bits, high byte keeps only four
    localparam logic [7:0] TEMP_HIGH_MASK = 8'h0f;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [31:0] DATA_ZERO = 32'h0000_0000;
endpackage : psr_pkg

// ==== hdl/psr_rom.sv ====
// psr_rom: factory byte store with a registered read port
`timescale 1ns/1ns
module psr_rom #(
    parameter int AW = 6,
    parameter logic [64*8-1:0] CONTENT = '0
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic rd_en,
    input wire logic [AW-1:0] rd_addr,
    output logic [7:0] rd_data
);
    logic [7:0] rd_data_reg;
    logic [7:0] rd_data_next;

    // the content vector is fixed at 64 bytes, so only a 6-bit index fits
    if (AW != 6) begin : g_aw_check
        $error("psr_rom serves a 64 byte store only");
    end

    // no write port at all: the store cannot be altered after build
    always_comb begin
        rd_data_next = rd_data_reg;
        if (rd_en) begin
            rd_data_next = CONTENT[rd_addr*8 +: 8];
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_data_reg <= 8'h00;
        end else if (clk_en) begin
            rd_data_reg <= rd_data_next;
        end
    end

    assign rd_data = rd_data_reg;
endmodule : psr_rom

// ==== hdl/psr_bank.sv ====
// psr_bank: read-only production signature bank behind an axi4-lite slave
//
// Operation
// - Lot number byte 0 reads back as a fixed byte at offset 0x08.
// - Lot number bytes 1 to 5 read back at offsets 0x09 through 0x0d.
// - The wafer number at 0x10 always reads its upper three bits as zero.
// - Die x and y positions are two bytes each, low first, 0x12 to 0x15.
// - The usb pad bytes at 0x1a are never copied out; software moves them.
// - Converter a trim bytes at 0x20 are not loaded; software copies them.
// - Converter b trim bytes at 0x24/0x25 are held but never loaded.
// - The 12-bit 85 degree temperature reading sits in two bytes at 0x2e.
//
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/1ns
module psr_bank #(
    parameter logic [7:0] LOT_B0 = 8'h11,
    parameter logic [7:0] LOT_B1 = 8'h22,
    parameter logic [7:0] LOT_B2 = 8'h33,
    parameter logic [7:0] LOT_B3 = 8'h44,
    parameter logic [7:0] LOT_B4 = 8'h55,
    parameter logic [7:0] LOT_B5 = 8'h66,
    parameter logic [7:0] WAFER = 8'h0a,
    parameter logic [15:0] DIE_X = 16'h0102,
    parameter logic [15:0] DIE_Y = 16'h0304,
    parameter logic [15:0] USB_TRIM = 16'h0506,
    parameter logic [7:0] OSC48_TRIM = 8'h07,
    parameter logic [15:0] CONVA_TRIM = 16'h0809,
    parameter logic [15:0] CONVB_TRIM = 16'h0a0b,
    parameter logic [11:0] TEMP_85C = 12'h0c0d
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    ////////////////////////////////////////////////////////////////////////
    // factory image
    typedef enum logic [1:0] {PSR_RD_IDLE, PSR_RD_FETCH, PSR_RD_ANSWER}
        psr_rd_state_t;

    // every factory byte has one entry: the slot it sits in
    localparam int SLOT_CNT = 20;
    localparam logic [7:0] SLOT_OFS [SLOT_CNT] = '{
        // lot number, lowest byte first
        psr_pkg::OFS_LOT0,
        psr_pkg::OFS_LOT1,
        psr_pkg::OFS_LOT2,
        psr_pkg::OFS_LOT3,
        psr_pkg::OFS_LOT4,
        psr_pkg::OFS_LOT5,
        // wafer number, then die x and y, low byte first
        psr_pkg::OFS_WAFER,
        psr_pkg::OFS_X_LOW,
        psr_pkg::OFS_X_HIGH,
        psr_pkg::OFS_Y_LOW,
        psr_pkg::OFS_Y_HIGH,
        // trims that software copies into their peripherals
        psr_pkg::OFS_USB_LOW,
        psr_pkg::OFS_USB_HIGH,
        psr_pkg::OFS_OSC48,
        psr_pkg::OFS_CONVA_LOW,
        psr_pkg::OFS_CONVA_HIGH,
        psr_pkg::OFS_CONVB_LOW,
        psr_pkg::OFS_CONVB_HIGH,
        // temperature reading taken in production
        psr_pkg::OFS_TEMP_LOW,
        psr_pkg::OFS_TEMP_HIGH
    };

    // value of entry k, with the bits that always read zero cleared
    function automatic logic [7:0] psr_slot_byte(input int k);
        logic [7:0] b;
        case (k)
            0: b = LOT_B0;
            1: b = LOT_B1;
            2: b = LOT_B2;
            3: b = LOT_B3;
            4: b = LOT_B4;
            5: b = LOT_B5;
            6: b = WAFER & psr_pkg::WAFER_MASK;
            7: b = DIE_X[7:0];
            8: b = DIE_X[15:8];
            9: b = DIE_Y[7:0];
            10: b = DIE_Y[15:8];
            11: b = USB_TRIM[7:0];
            12: b = USB_TRIM[15:8];
            13: b = OSC48_TRIM;
            14: b = CONVA_TRIM[7:0];
            15: b = CONVA_TRIM[15:8];
            16: b = CONVB_TRIM[7:0];
            17: b = CONVB_TRIM[15:8];
            18: b = TEMP_85C[7:0];
            19: b = {4'h0, TEMP_85C[11:8]} & psr_pkg::TEMP_HIGH_MASK;
            default: b = 8'h00;
        endcase
        return b;
    endfunction : psr_slot_byte

    // the image is assembled at build time; slots not listed read zero
    function automatic logic [64*8-1:0] psr_image();
        logic [64*8-1:0] img;
        img = '0;
        for (int k = 0; k < SLOT_CNT; k++) begin
            img[SLOT_OFS[k]*8 +: 8] = psr_slot_byte(k);
        end
        return img;
    endfunction : psr_image

    // build-time guard: a table edit that leaves the store or puts two
    // fields into one slot would otherwise silently shadow a byte
    if ((1 << psr_pkg::BANK_AW) != psr_pkg::BANK_DEPTH) begin : g_depth_chk
        $error("psr_bank store depth and index width disagree");
    end
    for (genvar i = 0; i < SLOT_CNT; i++) begin : g_slot_chk
        if (SLOT_OFS[i] >= psr_pkg::BANK_DEPTH) begin : g_range
            $error("psr_bank slot outside the store");
        end
        for (genvar j = i + 1; j < SLOT_CNT; j++) begin : g_pair
            if (SLOT_OFS[i] == SLOT_OFS[j]) begin : g_clash
                $error("psr_bank two fields share one slot");
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read channel
    psr_rd_state_t rd_state_reg;
    psr_rd_state_t rd_state_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic [1:0] rresp_reg;
    logic [1:0] rresp_next;
    logic [5:0] rd_index_reg;
    logic [5:0] rd_index_next;
    logic rd_in_range_reg;
    logic rd_in_range_next;
    logic rom_rd_en;
    logic [7:0] rom_rd_data;

    psr_rom #(
        .AW(psr_pkg::BANK_AW),
        .CONTENT(psr_image())
    ) u_rom (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .rd_en(rom_rd_en),
        .rd_addr(rd_index_next),
        .rd_data(rom_rd_data)
    );

    // nothing is taken or handed over while frozen, so no beat is lost on
    // a frozen edge; the price is that a valid drops for those cycles
    assign s_axi_arready = (rd_state_reg == PSR_RD_IDLE) && clk_en;

    // word index = byte address / 4; every address lands in the bank and is answered okay
    always_comb begin
        rd_state_next = rd_state_reg;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        rd_index_next = rd_index_reg;
        rd_in_range_next = rd_in_range_reg;
        rom_rd_en = 1'b0;
        case (rd_state_reg)
            PSR_RD_IDLE: begin
                if (s_axi_arvalid) begin
                    rd_index_next = s_axi_araddr[7:2];
                    rd_in_range_next = 1'b1;
                    rom_rd_en = 1'b1;
                    rd_state_next = PSR_RD_FETCH;
                end
            end
            PSR_RD_FETCH: begin
                rdata_next = {24'h000000, rom_rd_data};
                rresp_next = rd_in_range_reg ? psr_pkg::RESP_OKAY
                                             : psr_pkg::RESP_SLVERR;
                rd_state_next = PSR_RD_ANSWER;
            end
            PSR_RD_ANSWER: begin
                if (s_axi_rready) begin
                    rd_state_next = PSR_RD_IDLE;
                end
            end
            default: begin
                rd_state_next = PSR_RD_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_state_reg <= PSR_RD_IDLE;
            rdata_reg <= psr_pkg::DATA_ZERO;
            rresp_reg <= psr_pkg::RESP_OKAY;
            rd_index_reg <= 6'h00;
            rd_in_range_reg <= 1'b0;
        end else if (clk_en) begin
            rd_state_reg <= rd_state_next;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
            rd_index_reg <= rd_index_next;
            rd_in_range_reg <= rd_in_range_next;
        end
    end

    assign s_axi_rvalid = (rd_state_reg == PSR_RD_ANSWER) && clk_en;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;

    ////////////////////////////////////////////////////////////////////////
    // write channel: accepted and answered, contents never change
    logic aw_got_reg;
    logic aw_got_next;
    logic w_got_reg;
    logic w_got_next;
    logic bvalid_reg;
    logic bvalid_next;

    assign s_axi_awready = !aw_got_reg && !bvalid_reg && clk_en;
    assign s_axi_wready = !w_got_reg && !bvalid_reg && clk_en;

    // write data and strobes are dropped on purpose: the store is read-only
    always_comb begin
        aw_got_next = aw_got_reg;
        w_got_next = w_got_reg;
        bvalid_next = bvalid_reg;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_got_next = 1'b1;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_got_next = 1'b1;
        end
        if (bvalid_reg) begin
            if (s_axi_bready) begin
                bvalid_next = 1'b0;
            end
        end else if (aw_got_next && w_got_next) begin
            bvalid_next = 1'b1;
            aw_got_next = 1'b0;
            w_got_next = 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            aw_got_reg <= 1'b0;
            w_got_reg <= 1'b0;
            bvalid_reg <= 1'b0;
        end else if (clk_en) begin
            aw_got_reg <= aw_got_next;
            w_got_reg <= w_got_next;
            bvalid_reg <= bvalid_next;
        end
    end

    assign s_axi_bvalid = bvalid_reg && clk_en;
    // a write is refused with slverr so software sees the bank is read-only
    assign s_axi_bresp = psr_pkg::RESP_SLVERR;
endmodule : psr_bank

// ==== test/psr_bank_properties.sv ====
// psr_bank_properties: port-level checks of the signature bank slave
`timescale 1ns/1ns
module psr_bank_properties (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // byte offset of the read in flight, so content checks know the slot
    logic [7:0] rd_ofs_reg;
    logic [7:0] rd_ofs_next;
    always_comb begin
        rd_ofs_next = rd_ofs_reg;
        if (s_axi_arvalid && s_axi_arready) begin
            rd_ofs_next = {2'h0, s_axi_araddr[7:2]};
        end
    end
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_ofs_reg <= 8'h00;
        end else begin
            rd_ofs_reg <= rd_ofs_next;
        end
    end
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);
    a_read_latency: assert property (s_axi_arvalid && s_axi_arready |=>
        !s_axi_rvalid ##[1:2] s_axi_rvalid) else $error("read answer late");
    a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");
    a_read_okay: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] ==
        24'h0 && s_axi_rresp == psr_pkg::RESP_OKAY) else $error("bad read");
    a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while answering");
    a_wafer_top: assert property (s_axi_rvalid &&
        rd_ofs_reg == psr_pkg::OFS_WAFER |-> s_axi_rdata[7:5] == 3'h0)
        else $error("wafer top bits set");
    a_temp_top: assert property (s_axi_rvalid &&
        rd_ofs_reg == psr_pkg::OFS_TEMP_HIGH |-> s_axi_rdata[7:4] == 4'h0)
        else $error("temperature above 12 bits");
    a_write_slverr: assert property (s_axi_bvalid |->
        s_axi_bresp == psr_pkg::RESP_SLVERR) else $error("write not refused");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
        s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
        else $error("write answer missing");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid) else $error("write answer dropped");
    c_read: cover property (s_axi_rvalid && s_axi_rready);
    c_write: cover property (s_axi_bvalid && s_axi_bready);
    c_wafer: cover property (s_axi_rvalid && rd_ofs_reg == psr_pkg::OFS_WAFER);
endmodule : psr_bank_properties

// ==== test/tb_top.sv ====
// tb_top: directed axi4-lite reads and writes against the signature bank
`timescale 1ns/1ns
module tb_top;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic [7:0] s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic [31:0] s_axi_rdata, rd, ex;
    int error_cnt = 0;
    int total_checks = 0;
    int cyc = 0;
    logic [87:0] serial = '0;
    logic [23:0] loop_cfg;
    // lot, wafer and die position bytes in slot order
    localparam logic [87:0] SERIAL_EXP = 88'h1122_3344_5566_0ad4_c304_03;
    // the fast loop's compare pair that software sets beside the trim
    localparam logic [15:0] LOOP_CMP = 16'hb71b;
    // unnamed slot 0x00 closes the table and reads as zero
    localparam logic [7:0] OFS [21] = '{8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c,
        8'h0d, 8'h10, 8'h12, 8'h13, 8'h14, 8'h15, 8'h1a, 8'h1b, 8'h1c,
        8'h20, 8'h21, 8'h24, 8'h25, 8'h2e, 8'h2f, 8'h00};
    localparam logic [7:0] EXP [21] = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55,
        8'h66, 8'h0a, 8'hd4, 8'hc3, 8'h04, 8'h03, 8'h06, 8'h05, 8'h07,
        8'h09, 8'h08, 8'h0b, 8'h0a, 8'hbc, 8'h0a, 8'h00};
    always #5 core_clk = ~core_clk;
    // wafer carries set top bits so the masking shows; the 12-bit temperature has no bits above bit 11 to mask
    psr_bank #(
        .LOT_B0(8'h11), .LOT_B1(8'h22), .LOT_B2(8'h33), .LOT_B3(8'h44),
        .LOT_B4(8'h55), .LOT_B5(8'h66), .WAFER(8'hea), .DIE_X(16'hc3d4),
        .DIE_Y(16'h0304), .USB_TRIM(16'h0506), .OSC48_TRIM(8'h07),
        .CONVA_TRIM(16'h0809), .CONVB_TRIM(16'h0a0b), .TEMP_85C(12'habc)
    ) u_psr_bank (
        .core_clk(core_clk), .reset_n(reset_n), .clk_en(1'b1),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready));
    task automatic chk_data(input string w, input logic [31:0] e,
        input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", w, e, g);
        end
    endtask : chk_data
    task automatic chk_resp(input string w, input logic [1:0] e,
        input logic [1:0] g);
        total_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", w, e, g);
        end
    endtask : chk_resp
    task automatic chk_serial(input string w, input logic [87:0] e,
        input logic [87:0] g);
        total_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", w, e, g);
        end
    endtask : chk_serial
    task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
        output logic [1:0] r);
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        @(negedge core_clk);
        while (s_axi_arready !== 1'b1) @(negedge core_clk);
        @(posedge core_clk);
        s_axi_arvalid <= 1'b0;
        @(negedge core_clk);
        while (s_axi_rvalid !== 1'b1) @(negedge core_clk);
        d = s_axi_rdata;
        r = s_axi_rresp;
        @(posedge core_clk);
        s_axi_rready <= 1'b0;
    endtask : axi_read
    task automatic axi_write(input logic [7:0] a, output logic [1:0] r);
        logic pa, pw, ta, tw;
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= 32'hffff_ffff;
        s_axi_wstrb <= 4'hf;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        pa = 1'b1;
        pw = 1'b1;
        // the slave may take address and data on different edges
        while (pa || pw) begin
            @(negedge core_clk);
            ta = pa && (s_axi_awready === 1'b1);
            tw = pw && (s_axi_wready === 1'b1);
            @(posedge core_clk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            pa = pa && !ta;
            pw = pw && !tw;
        end
        @(negedge core_clk);
        while (s_axi_bvalid !== 1'b1) @(negedge core_clk);
        r = s_axi_bresp;
        @(posedge core_clk);
        s_axi_bready <= 1'b0;
    endtask : axi_write
    task wrap_up;
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : wrap_up
    // the whole run needs well under a thousand cycles
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            error_cnt++;
            wrap_up();
        end
    end
    initial begin
        repeat (20) @(posedge core_clk);
        reset_n <= 1'b1;
        for (int i = 0; i < 21; i++) begin
            axi_read({OFS[i][5:0], 2'h0}, rd, rs);
            ex = {24'h0, EXP[i]};
            chk_data("byte", ex, rd);
            chk_resp("read resp", psr_pkg::RESP_OKAY, rs);
        end
        $display("test contents done");
        for (int i = 0; i < 21; i += 5) begin
            axi_write({OFS[i][5:0], 2'h0}, rs);
            chk_resp("write resp", psr_pkg::RESP_SLVERR, rs);
            axi_read({OFS[i][5:0], 2'h0}, rd, rs);
            ex = {24'h0, EXP[i]};
            chk_data("after write", ex, rd);
        end
        $display("test write ignored done");
        // software side: serial id, then the fast loop set-up
        for (int i = 0; i < 11; i++) begin
            axi_read({OFS[i][5:0], 2'h0}, rd, rs);
            serial = {serial[79:0], rd[7:0]};
        end
        chk_serial("serial id", SERIAL_EXP, serial);
        axi_read(8'h70, rd, rs);
        loop_cfg = {LOOP_CMP, rd[7:0]};
        chk_data("loop setup", 32'h00b7_1b07, {8'h00, loop_cfg});
        $display("test software setup done");
        wrap_up();
    end
endmodule : tb_top
bind psr_bank psr_bank_properties u_psr_bank_properties (
    .core_clk(core_clk), .reset_n(reset_n), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready));
